// >>> hw/cpusc_pkg.sv
// Purpose: constants and types for the processor-side bus cycle driver
// Assumes: clk at 20 MHz (50 ns); cycle counts derived from the controller's least times
// Notes: status bytes below are what the controller latches on the strobe
package cpusc_pkg;

  // status bit positions
  localparam int unsigned BIT_INT_ACK = 0;
  localparam int unsigned BIT_WRITE_OUTPUT_N = 1;
  localparam int unsigned BIT_STACK = 2;
  localparam int unsigned BIT_HALT_ACK = 3;
  localparam int unsigned BIT_OUTPUT = 4;
  localparam int unsigned BIT_OPCODE_FETCH = 5;
  localparam int unsigned BIT_INPUT_CYCLE = 6;
  localparam int unsigned BIT_MEM_READ = 7;

  // status bytes per machine cycle
  localparam logic [7:0] STS_FETCH = 8'hA2;
  localparam logic [7:0] STS_MEM_RD = 8'h82;
  localparam logic [7:0] STS_MEM_WR = 8'h00;
  localparam logic [7:0] STS_STK_RD = 8'h86;
  localparam logic [7:0] STS_STK_WR = 8'h04;
  localparam logic [7:0] STS_IN_RD = 8'h42;
  localparam logic [7:0] STS_OUT_WR = 8'h10;
  localparam logic [7:0] STS_INT_ACK = 8'h23;
  localparam logic [7:0] STS_HALT_ACK = 8'h8A;
  localparam logic [7:0] STS_INT_ACK_HALT = 8'h2B;

  // opcode the controller inserts in single-vector mode
  localparam logic [7:0] RESTART7_OPCODE = 8'hFF;

  // timing in ns, and cycles derived from the clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int STS_SETUP_NS = 12;
  localparam int STROBE_WIDTH_NS = 22;
  localparam int STS_HOLD_NS = 5;
  localparam int READ_ENABLE_NS = 45;
  localparam int READ_PASS_NS = 30;
  localparam int WRITE_CTRL_NS = 45;
  // least times round up, never below one cycle
  localparam int SETUP_CYC = (STS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (STS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC =
    (READ_ENABLE_NS + READ_PASS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (WRITE_CTRL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    CYC_FETCH,
    CYC_MEM_RD,
    CYC_MEM_WR,
    CYC_STK_RD,
    CYC_STK_WR,
    CYC_IN_RD,
    CYC_OUT_WR,
    CYC_INT_ACK,
    CYC_HALT_ACK,
    CYC_INT_ACK_HALT
  } cpusc_cycle_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_XFER,
    ST_GAP,
    ST_DMA
  } cpusc_state_e;

endpackage : cpusc_pkg

// >>> hw/cpusc_cyc_if.sv
// Purpose: carries a cycle kind to the status encoder and its decode back
// Assumes: purely combinational between the two modules
// Notes: none
`timescale 1ns/1ps
interface cpusc_cyc_if;
  cpusc_pkg::cpusc_cycle_e kind;
  logic [7:0] status;
  logic is_read;
  logic is_write;
  modport enc (input kind, output status, output is_read, output is_write);
  modport ctl (output kind, input status, input is_read, input is_write);
endinterface : cpusc_cyc_if

// >>> hw/cpusc_status_enc.sv
// Purpose: map a machine-cycle kind to its status byte and transfer direction
// Assumes: kind is one of the enum values
// Notes: halt acknowledge carries no data phase
`timescale 1ns/1ps
module cpusc_status_enc (
  cpusc_cyc_if.enc cyc
);
  logic [7:0] status_w;

  // status byte table
  always_comb begin
    unique case (cyc.kind)
      cpusc_pkg::CYC_FETCH: status_w = cpusc_pkg::STS_FETCH;
      cpusc_pkg::CYC_MEM_RD: status_w = cpusc_pkg::STS_MEM_RD;
      cpusc_pkg::CYC_MEM_WR: status_w = cpusc_pkg::STS_MEM_WR;
      cpusc_pkg::CYC_STK_RD: status_w = cpusc_pkg::STS_STK_RD;
      cpusc_pkg::CYC_STK_WR: status_w = cpusc_pkg::STS_STK_WR;
      cpusc_pkg::CYC_IN_RD: status_w = cpusc_pkg::STS_IN_RD;
      cpusc_pkg::CYC_OUT_WR: status_w = cpusc_pkg::STS_OUT_WR;
      cpusc_pkg::CYC_INT_ACK: status_w = cpusc_pkg::STS_INT_ACK;
      cpusc_pkg::CYC_HALT_ACK: status_w = cpusc_pkg::STS_HALT_ACK;
      cpusc_pkg::CYC_INT_ACK_HALT: status_w = cpusc_pkg::STS_INT_ACK_HALT;
      default: status_w = cpusc_pkg::STS_HALT_ACK; // illegal code: no data phase
    endcase
  end

  // direction from the write/output bit; halt alone moves no data
  assign cyc.status = status_w;
  assign cyc.is_write = ~status_w[cpusc_pkg::BIT_WRITE_OUTPUT_N];
  assign cyc.is_read = status_w[cpusc_pkg::BIT_WRITE_OUTPUT_N] &
    ~(status_w[cpusc_pkg::BIT_HALT_ACK] & ~status_w[cpusc_pkg::BIT_INT_ACK]);

endmodule : cpusc_status_enc

// >>> hw/cpusc_host.sv
// Purpose: processor-side driver of the system controller's pins
// Assumes: pins sampled synchronously to clk; one command at a time
// Notes: runs status, strobe, hold, then a data-in or write phase, none for halt acknowledge
`timescale 1ns/1ps
module cpusc_host #(
  parameter int STROBE_CYCLES = cpusc_pkg::STROBE_CYC,
  parameter int READ_CYCLES = cpusc_pkg::READ_CYC,
  parameter int WRITE_CYCLES = cpusc_pkg::WRITE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cpusc_pkg::cpusc_cycle_e cmd_kind,
  input wire logic [7:0] cmd_wdata,
  input wire logic [1:0] cmd_bytes,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  input wire logic dma_req,
  output logic dma_granted,
  output logic status_strobe_n,
  output logic cpu_data_in_strobe,
  output logic cpu_write_strobe_n,
  output logic hold_acknowledge_in,
  output logic bus_float_control,
  output logic [7:0] cpu_side_data_o,
  output logic cpu_side_data_oe,
  input wire logic [7:0] cpu_side_data_i
);
  cpusc_pkg::cpusc_state_e state_r, state_nxt;
  cpusc_pkg::cpusc_cycle_e kind_r, kind_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [1:0] left_r, left_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic status_strobe_n_n_r, status_strobe_n_n_nxt;
  logic cpu_data_in_strobe_r, cpu_data_in_strobe_nxt;
  logic wr_n_r, wr_n_nxt;
  logic float_r, float_nxt;
  logic rsp_r, rsp_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic cnt_done;
  logic is_int_ack;
  logic [1:0] bytes_eff;

  cpusc_cyc_if cyc ();

  cpusc_status_enc u_enc (
    .cyc(cyc.enc)
  );

  // encoder looks at the command in idle and the held kind afterwards
  assign cyc.kind = (state_r == cpusc_pkg::ST_IDLE) ? cmd_kind : kind_r;
  assign cnt_done = (cnt_r == 3'h0);
  assign is_int_ack = cyc.status[cpusc_pkg::BIT_INT_ACK];
  assign bytes_eff = (cmd_bytes == 2'h0) ? 2'h1 : cmd_bytes;
  // no new cycle while the bus is handed away
  assign cmd_ready = (state_r == cpusc_pkg::ST_IDLE) & ~dma_req;

  // next-state and pin sequencing
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_done ? 3'h0 : cnt_r - 3'h1;
    left_nxt = left_r;
    wdata_nxt = wdata_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    status_strobe_n_n_nxt = status_strobe_n_n_r;
    cpu_data_in_strobe_nxt = cpu_data_in_strobe_r;
    wr_n_nxt = wr_n_r;
    float_nxt = float_r;
    rsp_nxt = 1'b0;
    rdata_nxt = rdata_r;
    unique case (state_r)
      cpusc_pkg::ST_IDLE: begin
        if (dma_req) begin
          float_nxt = 1'b1;
          oe_nxt = 1'b0;
          state_nxt = cpusc_pkg::ST_DMA;
        end else if (cmd_valid) begin
          kind_nxt = cmd_kind;
          wdata_nxt = cmd_wdata;
          left_nxt = bytes_eff;
          dout_nxt = cyc.status;
          oe_nxt = 1'b1;
          cnt_nxt = 3'(cpusc_pkg::SETUP_CYC - 1);
          state_nxt = cpusc_pkg::ST_SETUP;
        end
      end
      cpusc_pkg::ST_SETUP: begin
        // status must be stable before the strobe falls
        if (cnt_done) begin
          status_strobe_n_n_nxt = 1'b0;
          cnt_nxt = 3'(STROBE_CYCLES - 1);
          state_nxt = cpusc_pkg::ST_STROBE;
        end
      end
      cpusc_pkg::ST_STROBE: begin
        if (cnt_done) begin
          status_strobe_n_n_nxt = 1'b1;
          cnt_nxt = 3'(cpusc_pkg::HOLD_CYC - 1);
          state_nxt = cpusc_pkg::ST_HOLD;
        end
      end
      cpusc_pkg::ST_HOLD: begin
        // status held past the strobe, then the data phase
        if (cnt_done) begin
          if (cyc.is_read) begin
            oe_nxt = 1'b0;
            cpu_data_in_strobe_nxt = 1'b1;
            cnt_nxt = 3'(READ_CYCLES - 1);
            state_nxt = cpusc_pkg::ST_XFER;
          end else if (cyc.is_write) begin
            dout_nxt = wdata_r;
            wr_n_nxt = 1'b0;
            cnt_nxt = 3'(WRITE_CYCLES - 1);
            state_nxt = cpusc_pkg::ST_XFER;
          end else begin
            oe_nxt = 1'b0;
            rsp_nxt = 1'b1;
            rdata_nxt = 8'h00;
            state_nxt = cpusc_pkg::ST_IDLE;
          end
        end
      end
      cpusc_pkg::ST_XFER: begin
        if (cnt_done) begin
          if (cpu_data_in_strobe_r) begin
            // sample at the end of data-in; the vector or restart byte arrives here
            rdata_nxt = cpu_side_data_i;
            cpu_data_in_strobe_nxt = 1'b0;
            rsp_nxt = 1'b1;
            left_nxt = left_r - 2'h1;
            state_nxt = (is_int_ack && left_r > 2'h1) ?
              cpusc_pkg::ST_GAP : cpusc_pkg::ST_IDLE;
          end else begin
            wr_n_nxt = 1'b1;
            state_nxt = cpusc_pkg::ST_GAP;
          end
        end
      end
      cpusc_pkg::ST_GAP: begin
        // after a write: data held one cycle past the strobe edge
        // between acknowledge bytes: data-in drops so each byte gets its own pulse
        if (wr_n_r && !is_int_ack) begin
          oe_nxt = 1'b0;
          rsp_nxt = 1'b1;
          rdata_nxt = 8'h00;
          state_nxt = cpusc_pkg::ST_IDLE;
        end else begin
          cpu_data_in_strobe_nxt = 1'b1;
          cnt_nxt = 3'(READ_CYCLES - 1);
          state_nxt = cpusc_pkg::ST_XFER;
        end
      end
      cpusc_pkg::ST_DMA: begin
        // bus given away; controller outputs float while this is high
        if (!dma_req) begin
          float_nxt = 1'b0;
          state_nxt = cpusc_pkg::ST_IDLE;
        end
      end
      // unused state code: fall back to idle rather than lock up
      default: state_nxt = cpusc_pkg::ST_IDLE;
    endcase
  end

  // state and sequencing registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= cpusc_pkg::ST_IDLE;
      kind_r <= cpusc_pkg::CYC_FETCH;
      cnt_r <= 3'h0;
      left_r <= 2'h0;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      rsp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      left_r <= left_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // pin registers, all idle-inactive after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_r <= 8'h00;
      oe_r <= 1'b0;
      status_strobe_n_n_r <= 1'b1;
      cpu_data_in_strobe_r <= 1'b0;
      wr_n_r <= 1'b1;
      float_r <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      status_strobe_n_n_r <= status_strobe_n_n_nxt;
      cpu_data_in_strobe_r <= cpu_data_in_strobe_nxt;
      wr_n_r <= wr_n_nxt;
      float_r <= float_nxt;
    end
  end

  // hold acknowledge follows the float request, gating the memory read strobe off
  assign hold_acknowledge_in = float_r;
  assign bus_float_control = float_r;
  assign dma_granted = float_r;
  assign status_strobe_n = status_strobe_n_n_r;
  assign cpu_data_in_strobe = cpu_data_in_strobe_r;
  assign cpu_write_strobe_n = wr_n_r;
  assign cpu_side_data_o = dout_r;
  assign cpu_side_data_oe = oe_r;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;

endmodule : cpusc_host

// >>> test/cpusc_host_monitor.sv
// Purpose: pin-level checks on the processor-side driver
// Assumes: one clock, asynchronous active-low reset
// Notes: bound onto every cpusc_host instance
`timescale 1ns/1ps
module cpusc_host_monitor #(
  parameter int STROBE_CYCLES = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic dma_req,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata,
  input wire logic dma_granted,
  input wire logic status_strobe_n,
  input wire logic cpu_data_in_strobe,
  input wire logic cpu_write_strobe_n,
  input wire logic hold_acknowledge_in,
  input wire logic bus_float_control,
  input wire logic [7:0] cpu_side_data_o,
  input wire logic cpu_side_data_oe,
  input wire logic [7:0] cpu_side_data_i
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // status byte must stand on the bus on both sides of the strobe
  sequence s_sts_held;
    cpu_side_data_oe && $stable(cpu_side_data_o);
  endsequence
  sequence s_wr_pulse;
    cpu_side_data_oe ##1 (cpu_write_strobe_n && $stable(cpu_side_data_o));
  endsequence
  a_strobe_width: assert property ($fell(status_strobe_n)
    |-> ##STROBE_CYCLES $rose(status_strobe_n)) else $error("status strobe width off");
  a_status_setup: assert property ($fell(status_strobe_n) |-> s_sts_held)
    else $error("status not set up at strobe");
  a_status_hold: assert property ($rose(status_strobe_n) |-> s_sts_held)
    else $error("status not held after strobe");
  a_bus_release: assert property (cpu_data_in_strobe |-> !cpu_side_data_oe)
    else $error("bus driven during data-in");
  a_rd_wr_excl: assert property (!(cpu_data_in_strobe && !cpu_write_strobe_n))
    else $error("read and write strobes together");
  a_write_pulse: assert property ($fell(cpu_write_strobe_n) |-> s_wr_pulse)
    else $error("write data not held over strobe");
  a_read_capture: assert property ($fell(cpu_data_in_strobe)
    |-> rsp_valid && rsp_rdata == $past(cpu_side_data_i)) else $error("read byte lost");
  a_float_tied: assert property (bus_float_control == hold_acknowledge_in
    && dma_granted == bus_float_control) else $error("float, hold, grant differ");
  a_float_quiet: assert property (bus_float_control |-> status_strobe_n
    && !cpu_data_in_strobe && cpu_write_strobe_n && !cpu_side_data_oe)
    else $error("strobe while floated");
  a_float_end: assert property (bus_float_control && !dma_req |=> !bus_float_control)
    else $error("float not released");
endmodule : cpusc_host_monitor

bind cpusc_host cpusc_host_monitor #(.STROBE_CYCLES(STROBE_CYCLES)) cpusc_host_monitor_i (
  .clk(clk), .arst_n(arst_n), .dma_req(dma_req), .rsp_valid(rsp_valid),
  .rsp_rdata(rsp_rdata), .dma_granted(dma_granted), .status_strobe_n(status_strobe_n),
  .cpu_data_in_strobe(cpu_data_in_strobe), .cpu_write_strobe_n(cpu_write_strobe_n),
  .hold_acknowledge_in(hold_acknowledge_in), .bus_float_control(bus_float_control),
  .cpu_side_data_o(cpu_side_data_o), .cpu_side_data_oe(cpu_side_data_oe),
  .cpu_side_data_i(cpu_side_data_i)
);

// >>> test/cpusc_dev_model.sv
// Purpose: behavioural system controller with a one-byte memory
// Assumes: pins change only after clock edges
// Notes: strb_n is {ack, io write, mem write, io read, mem read}
`timescale 1ns/1ps
module cpusc_dev_model #(
  parameter logic [7:0] VEC_BYTE = 8'hC3
) (
  input wire logic status_strobe_n,
  input wire logic cpu_data_in_strobe,
  input wire logic cpu_write_strobe_n,
  input wire logic hold_acknowledge_in,
  input wire logic bus_float_control,
  input wire logic single_vec,
  input wire logic [7:0] cpu_side_data_o,
  input wire logic cpu_side_data_oe,
  output logic [7:0] cpu_side_data_i,
  output logic [7:0] sts_r,
  output logic [7:0] mem_r,
  output logic [4:0] strb_n
);
  logic [4:0] act;
  logic [7:0] drv;
  logic [7:0] last_r = 8'h00;
  // latch status on the falling strobe
  always @(negedge status_strobe_n) sts_r = cpu_side_data_o;
  // reads qualified by data-in, writes by the write strobe
  assign act[0] = sts_r[7] & cpu_data_in_strobe & ~hold_acknowledge_in;
  assign act[1] = sts_r[6] & cpu_data_in_strobe;
  assign act[2] = ~cpu_write_strobe_n & ~sts_r[4];
  assign act[3] = ~cpu_write_strobe_n & sts_r[4];
  assign act[4] = sts_r[0] & cpu_data_in_strobe;
  assign strb_n = bus_float_control ? {5{1'bz}} : ~act;
  // write data taken at strobe end, when it is surely stable
  initial mem_r = 8'h5A;
  always @(posedge cpu_write_strobe_n) if (cpu_side_data_oe) mem_r = cpu_side_data_o;
  // released bus shows the inverse of the last byte, never a stale copy
  assign drv = sts_r[0] ? (single_vec ? 8'hFF : VEC_BYTE) : mem_r;
  always @(negedge cpu_data_in_strobe) last_r = drv;
  assign cpu_side_data_i = cpu_data_in_strobe ? drv : ~last_r;
endmodule : cpusc_dev_model

// >>> test/tb.sv
// Purpose: self-checking bench for the processor-side driver
// Assumes: default cycle parameters
// Notes: every machine cycle kind is run at least once
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  cpusc_pkg::cpusc_cycle_e cmd_kind = cpusc_pkg::CYC_FETCH;
  logic [7:0] cmd_wdata = 8'h00;
  logic [1:0] cmd_bytes = 2'h0;
  logic dma_req = 1'b0;
  logic single_vec = 1'b1;
  logic cmd_ready, rsp_valid, dma_granted, status_strobe_n, cpu_data_in_strobe;
  logic cpu_write_strobe_n, hold_acknowledge_in, bus_float_control, cpu_side_data_oe;
  logic [7:0] rsp_rdata, cpu_side_data_o, cpu_side_data_i, sts, mem;
  logic [4:0] strb_n;
  logic [4:0] seen = 5'h00;
  int miscompares = 0, samples_checked = 0, cyc = 0, interrupt_ack_strobe_n_cnt = 0;
  logic [7:0] got[$];
  always #25 clk = ~clk;
  cpusc_host cpusc_host_i (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_wdata(cmd_wdata),
    .cmd_bytes(cmd_bytes), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .dma_req(dma_req), .dma_granted(dma_granted), .status_strobe_n(status_strobe_n),
    .cpu_data_in_strobe(cpu_data_in_strobe), .cpu_write_strobe_n(cpu_write_strobe_n),
    .hold_acknowledge_in(hold_acknowledge_in), .bus_float_control(bus_float_control),
    .cpu_side_data_o(cpu_side_data_o), .cpu_side_data_oe(cpu_side_data_oe),
    .cpu_side_data_i(cpu_side_data_i));
  cpusc_dev_model cpusc_dev_model_i (.status_strobe_n(status_strobe_n),
    .cpu_data_in_strobe(cpu_data_in_strobe), .cpu_write_strobe_n(cpu_write_strobe_n),
    .hold_acknowledge_in(hold_acknowledge_in), .bus_float_control(bus_float_control),
    .single_vec(single_vec), .cpu_side_data_o(cpu_side_data_o),
    .cpu_side_data_oe(cpu_side_data_oe), .cpu_side_data_i(cpu_side_data_i),
    .sts_r(sts), .mem_r(mem), .strb_n(strb_n));
  // strobes seen and acknowledge pulses since the last command
  always @(posedge clk) seen <= seen | ~strb_n;
  always @(negedge strb_n[4]) interrupt_ack_strobe_n_cnt++;
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic run_cmd(input cpusc_pkg::cpusc_cycle_e k, input logic [7:0] wd,
      input logic [1:0] nb, input int n);
    int t;
    t = 0;
    got.delete();
    @(posedge clk);
    #1;
    seen = 5'h00;
    interrupt_ack_strobe_n_cnt = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_wdata <= wd;
    cmd_bytes <= nb;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (got.size() < n && t < 40) begin
      @(posedge clk);
      #1;
      if (rsp_valid === 1'b1) got.push_back(rsp_rdata);
      t++;
    end
    repeat (2) @(posedge clk);
  endtask : run_cmd
  // all ten kinds in order; the memory byte follows the writes
  task automatic t_cycles();
    logic [7:0] sx [10] = '{8'hA2, 8'h82, 8'h00, 8'h86, 8'h04, 8'h42, 8'h10, 8'h23,
      8'h8A, 8'h2B};
    logic [4:0] mx [10] = '{5'h01, 5'h01, 5'h04, 5'h01, 5'h04, 5'h02, 5'h08, 5'h10,
      5'h00, 5'h10};
    logic [7:0] em;
    em = 8'h5A;
    for (int i = 0; i < 10; i++) begin
      run_cmd(cpusc_pkg::cpusc_cycle_e'(i), 8'h30 + 8'(i), 2'h2, (mx[i] == 5'h10) ? 2 : 1);
      if (mx[i][2] || mx[i][3]) em = 8'h30 + 8'(i);
      chk8(sts, sx[i]);
      chk8({3'h0, seen}, {3'h0, mx[i]});
      chk8(mem, em);
      chk8(got[0], (mx[i] & 5'h03) != 5'h00 ? em : {8{mx[i][4]}});
      chk8(8'(interrupt_ack_strobe_n_cnt), mx[i][4] ? 8'h02 : 8'h00);
    end
    $display("test cycles done");
  endtask : t_cycles
  // vector read from the bus, one acknowledge per byte
  task automatic t_vector();
    @(posedge clk);
    single_vec <= 1'b0;
    run_cmd(cpusc_pkg::CYC_INT_ACK, 8'h00, 2'h3, 3);
    chk8(8'(got.size()), 8'h03);
    foreach (got[j]) chk8(got[j], 8'hC3);
    chk8(8'(interrupt_ack_strobe_n_cnt), 8'h03);
    run_cmd(cpusc_pkg::CYC_INT_ACK, 8'h00, 2'h0, 1);
    chk8(8'(interrupt_ack_strobe_n_cnt), 8'h01);
    $display("test vector done");
  endtask : t_vector
  // bus float floats every strobe, then normal work resumes
  task automatic t_dma();
    @(posedge clk);
    dma_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk8({cmd_ready, dma_granted, hold_acknowledge_in, bus_float_control, 4'h0}, 8'h70);
    chk8({3'h0, strb_n}, {3'h0, {5{1'bz}}});
    @(posedge clk);
    dma_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk8({cmd_ready, bus_float_control, 6'h00}, 8'h80);
    run_cmd(cpusc_pkg::CYC_MEM_RD, 8'h00, 2'h0, 1);
    chk8(got[0], mem);
    $display("test dma done");
  endtask : t_dma
  task automatic finish_test();
    $display("checked %0d, wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk8({status_strobe_n, cpu_data_in_strobe, cpu_write_strobe_n, cpu_side_data_oe,
      bus_float_control, cmd_ready, 2'h0}, 8'hA4);
    $display("test reset done");
    t_cycles();
    t_vector();
    t_dma();
    finish_test();
  end
endmodule : tb
